// >>> dv/asp_host_model.sv
// Behavioural serial host that clocks control words in and results out
`timescale 1ns/1ps
module asp_host_model (
  input wire logic clk_i,
  input wire logic dout_i,
  input wire logic strobe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  logic hang = 1'b0;
  logic lo_seen = 1'b0;
  initial begin
    sclk_o = 0;
    cs_n_o = 1;
    din_o = 0;
  end
  // 200 ns per half keeps the duty cycle at 50%
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic xfer(input logic [7:0] ctrl, input int n, input logic sel,
                      output logic [23:0] rx);
    rx = '0;
    hang = 1'b0;
    lo_seen = 1'b0;
    cs_n_o = !sel;
    half();
    for (int k = 0; k < n; k++) begin
      din_o = (k < 8) ? ctrl[7-k] : 1'b0;
      half();
      sclk_o = 1;
      rx = {rx[22:0], dout_i};
      half();
      sclk_o = 0;
      if (k == 7 && !ctrl[0]) begin
        // Internal timing: hold the clock until the strobe reports done
        half();
        lo_seen = (strobe_i === 1'b0);
        for (int w = 0; w < 200 && strobe_i !== 1'b1; w++) @(negedge clk_i);
        // A wait that runs out is reported to the bench as a mismatch
        hang = (strobe_i !== 1'b1);
      end
    end
    half();
    cs_n_o = 1;
    half();
  endtask
endmodule

// >>> dv/asp_top_sva.sv
// Port-level assertions for the serial converter pin interface
`timescale 1ns/1ps
module asp_top_sva
  import asp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic [1:0] three_level_powerdown_input_i,
  input wire logic [RES_BITS-1:0] sample_code_i,
  input wire logic dout_o,
  input wire logic dout_oe_n_o,
  input wire logic conversion_strobe_o,
  input wire logic conversion_strobe_oe_n_o,
  input wire logic track_o,
  input wire logic shutdown_o,
  input wire logic ext_comp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Sequences
  sequence s_desel; cs_n_i [*5]; endsequence
  sequence s_sel; !cs_n_i [*5]; endsequence
  sequence s_rise; $rose(conversion_strobe_o) ##0 !cs_n_i; endsequence
  // ==========================================
  // Properties
  property p_hiz; s_desel |-> dout_oe_n_o; endproperty
  a_hiz: assert property (p_hiz) else $error("dout driven while deselected");
  property p_drive; s_sel |-> !dout_oe_n_o && !conversion_strobe_oe_n_o; endproperty
  a_drive: assert property (p_drive) else $error("outputs off while selected");
  property p_dout_edge; $changed(dout_o) |-> !sclk_i; endproperty
  a_dout_edge: assert property (p_dout_edge) else $error("dout moved with clock high");
  property p_trk_edge; $changed(track_o) |-> !sclk_i; endproperty
  a_trk_edge: assert property (p_trk_edge) else $error("track moved with clock high");
  property p_strb; s_rise |-> conversion_strobe_o [*7]; endproperty
  a_strb: assert property (p_strb) else $error("strobe pulse too short");
  property p_pd_low; (three_level_powerdown_input_i == TLPD_LOW) [*5] |-> shutdown_o; endproperty
  a_pd_low: assert property (p_pd_low) else $error("no shutdown");
  property p_pd_hi;
    (three_level_powerdown_input_i == TLPD_HIGH) [*5] |-> !shutdown_o && !ext_comp_o;
  endproperty
  a_pd_hi: assert property (p_pd_hi) else $error("high level decode");
  property p_pd_fl;
    (three_level_powerdown_input_i == TLPD_FLOAT) [*5] |-> !shutdown_o && ext_comp_o;
  endproperty
  a_pd_fl: assert property (p_pd_fl) else $error("float level decode");
endmodule
bind asp_top asp_top_sva chk (.*);

// >>> dv/test_asp_top.sv
// Self-checking bench for the serial converter pin interface
`timescale 1ns/1ps
module test_asp_top
  import asp_pkg::*;
;
  logic clk_i = 0;
  logic rst_i = 1;
  logic trk_seen = 0;
  logic [1:0] pd = TLPD_HIGH;
  logic [1:0] lv [3] = '{TLPD_FLOAT, TLPD_LOW, TLPD_HIGH};
  logic [RES_BITS-1:0] code = '0;
  logic [7:0] ctrl;
  logic [23:0] rx;
  wire sclk, cs_n, din, dout, dout_oe_n, strb, strb_oe_n, trk, sd, ec;
  int failures = 0;
  int total_checks = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (trk === 1'b1) trk_seen <= 1'b1;
  asp_top uut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .three_level_powerdown_input_i(pd), .sample_code_i(code), .dout_o(dout),
    .dout_oe_n_o(dout_oe_n), .conversion_strobe_o(strb), .conversion_strobe_oe_n_o(strb_oe_n),
    .track_o(trk), .shutdown_o(sd), .ext_comp_o(ec));
  asp_host_model host (.clk_i(clk_i), .dout_i(dout_oe_n ? 1'bz : dout),
    .strobe_i(strb_oe_n ? 1'bz : strb), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Low keeps the compensation bit, which the float step before it set
  function automatic logic [1:0] pd_exp(input logic [1:0] c);
    return {c == TLPD_LOW, c != TLPD_HIGH};
  endfunction
  initial begin
    void'($urandom(32'hC3ED));
    repeat (2) @(negedge clk_i);
    rst_i = 0;
    foreach (lv[i]) begin
      pd = lv[i];
      repeat (6) @(negedge clk_i);
      chk(10'({sd, ec}), 10'(pd_exp(lv[i])));
    end
    host.xfer(8'hFF, 24, 1'b0, rx);
    chk(10'({trk_seen, dout_oe_n}), 10'h001);
    host.xfer(8'hFF, 6, 1'b1, rx);
    for (int i = 0; i < 10; i++) begin
      code = (i < 4) ? (i[1] ? 10'h3FF : 10'h000) : 10'($urandom);
      ctrl = {1'b1, 6'($urandom), (i < 4) ? i[0] : 1'($urandom)};
      trk_seen = 0;
      host.xfer(ctrl, 24, 1'b1, rx);
      chk(rx[14:5], code);
      chk(10'({host.hang, host.lo_seen}), {9'h000, ~ctrl[0]});
      chk(10'({strb_oe_n, dout_oe_n}), {8'h00, ctrl[0], 1'b1});
      chk(10'(trk_seen), 10'h001);
    end
    final_report();
  end
  initial begin
    #3000000;
    failures++;
    final_report();
  end
endmodule

// >>> hw/asp_pkg.sv
// Shared constants for the serial converter pin interface
package asp_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int INT_STEP_NS = 400;
  localparam int INT_STEP_CYC =
    (INT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Control word and result layout
  localparam int CTRL_BITS = 8;
  localparam int TRACK_BIT = 5;
  localparam int RES_BITS = 10;
  localparam int EXT_MODE_POS = 0;
  localparam int SYNC_W = 5 + RES_BITS;

  // ==========================================================
  // Three-level shutdown input codes
  localparam logic [1:0] TLPD_LOW = 2'h0;
  localparam logic [1:0] TLPD_FLOAT = 2'h1;
  localparam logic [1:0] TLPD_HIGH = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [3:0] BITCNT_RST = 4'h0;
  localparam logic [RES_BITS-1:0] RES_RST = 10'h000;
  localparam logic [7:0] CTRL_RST = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CTRL = 5'b00010,
    ST_CONV_EXT = 5'b00100,
    ST_CONV_INT = 5'b01000,
    ST_READ = 5'b10000
  } asp_state_t;

endpackage

// >>> hw/asp_sync.sv
// Two-stage synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ps
module asp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// >>> hw/asp_top.sv
// Serial pin interface and conversion sequencing of an 8-channel 10-bit converter
`timescale 1ns/1ps
module asp_top
  import asp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic [1:0] three_level_powerdown_input_i,
  input wire logic [RES_BITS-1:0] sample_code_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  output logic conversion_strobe_o,
  output logic conversion_strobe_oe_n_o,
  output logic track_o,
  output logic shutdown_o,
  output logic ext_comp_o
);

  // ==========================================================
  // Input synchronisation and serial clock edges
  logic [SYNC_W-1:0] sync_q;
  logic sclk_s;
  logic cs_n_s;
  logic sel_s;
  logic din_s;
  logic [1:0] tlpd_s;
  logic [1:0] tlpd_q;
  logic [RES_BITS-1:0] code_s;
  logic sclk_d;
  logic rise;
  logic fall;

  // Select and level code pass inverted so cleared flops read as deselected and
  // operational; otherwise the pins would look selected and shut down after reset
  asp_sync #(.W(SYNC_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({sclk_i, ~cs_n_i, din_i, ~three_level_powerdown_input_i, sample_code_i}),
    .q_o(sync_q)
  );

  assign {sclk_s, sel_s, din_s, tlpd_q, code_s} = sync_q;
  assign cs_n_s = ~sel_s;
  assign tlpd_s = ~tlpd_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  // ==========================================================
  // Shutdown pin decode
  function automatic logic is_low(input logic [1:0] lvl);
    is_low = (lvl == TLPD_LOW);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shutdown_o <= 1'b0;
      ext_comp_o <= 1'b0;
    end else begin
      shutdown_o <= is_low(tlpd_s);
      if (!is_low(tlpd_s)) begin
        ext_comp_o <= (tlpd_s == TLPD_FLOAT);
      end
    end
  end

  // ==========================================================
  // Sequencer
  asp_state_t state;
  logic [3:0] bitcnt;
  logic [7:0] ctrl;
  logic ext_mode;
  logic [RES_BITS-1:0] result;
  logic [RES_BITS-1:0] held_code;
  logic [3:0] step;
  logic [3:0] divcnt;
  logic step_en;
  logic [RES_BITS-1:0] trial;
  logic decide;
  logic active;

  assign active = ~cs_n_s & ~is_low(tlpd_s);
  // Successive approximation: keep the trial bit if the held sample reaches it
  assign trial = result | (RES_BITS'(1) << step);
  assign decide = (held_code >= trial);

  // Internal conversion clock as an enable pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || state != ST_CONV_INT) begin
      divcnt <= 4'h0;
      step_en <= 1'b0;
    end else if (divcnt == 4'(INT_STEP_CYC - 1)) begin
      divcnt <= 4'h0;
      step_en <= 1'b1;
    end else begin
      divcnt <= divcnt + 4'h1;
      step_en <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || is_low(tlpd_s)) begin
      state <= ST_IDLE;
      bitcnt <= BITCNT_RST;
      ctrl <= CTRL_RST;
      ext_mode <= 1'b0;
      result <= RES_RST;
      held_code <= RES_RST;
      step <= 4'h0;
      track_o <= 1'b0;
      dout_o <= 1'b0;
      conversion_strobe_o <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          // The first 1 seen with select low opens the control word
          if (active && rise && din_s) begin
            ctrl <= {7'h00, 1'b1};
            bitcnt <= 4'h1;
            state <= ST_CTRL;
          end
        end
        ST_CTRL: begin
          if (cs_n_s) begin
            state <= ST_IDLE;
            track_o <= 1'b0;
          end else if (rise) begin
            ctrl <= {ctrl[6:0], din_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (fall && bitcnt == 4'(TRACK_BIT)) begin
            track_o <= 1'b1;
          end else if (fall && bitcnt == 4'(CTRL_BITS)) begin
            track_o <= 1'b0;
            held_code <= code_s;
            result <= RES_RST;
            step <= 4'(RES_BITS - 1);
            ext_mode <= ctrl[EXT_MODE_POS];
            if (ctrl[EXT_MODE_POS]) begin
              conversion_strobe_o <= 1'b1;
              state <= ST_CONV_EXT;
            end else begin
              conversion_strobe_o <= 1'b0;
              state <= ST_CONV_INT;
            end
          end
        end
        ST_CONV_EXT: begin
          if (cs_n_s) begin
            state <= ST_IDLE;
          end else if (fall) begin
            // One decision per serial clock, bit leaves on the same edge
            conversion_strobe_o <= 1'b0;
            result[step] <= decide;
            dout_o <= decide;
            step <= step - 4'h1;
            if (step == 4'h0) begin
              state <= ST_READ;
            end
          end
        end
        ST_CONV_INT: begin
          // Runs to completion on the internal clock even if select rises
          if (step_en) begin
            result[step] <= decide;
            step <= step - 4'h1;
            if (step == 4'h0) begin
              conversion_strobe_o <= 1'b1;
              state <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (cs_n_s) begin
            state <= ST_IDLE;
            dout_o <= 1'b0;
          end else if (fall) begin
            // Internal mode shifts the stored code MSB first, then zeros
            dout_o <= ext_mode ? 1'b0 : result[RES_BITS-1];
            result <= {result[RES_BITS-2:0], 1'b0};
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Output enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_oe_n_o <= 1'b1;
      conversion_strobe_oe_n_o <= 1'b0;
    end else begin
      dout_oe_n_o <= cs_n_s;
      conversion_strobe_oe_n_o <= ext_mode & cs_n_s;
    end
  end

endmodule
